// ===== design/debug_user_row_map.svh
`ifndef DEBUG_USER_ROW_MAP_SVH
`define DEBUG_USER_ROW_MAP_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define DUR_OFF_REVISION   4'h0
`define DUR_OFF_ERROR      4'h1
`define DUR_OFF_LINK_CTRL  4'h2
`define DUR_OFF_LINK_DIS   4'h3
`define DUR_OFF_KEY_STAT   4'h7
`define DUR_OFF_RST_REQ    4'h8
`define DUR_OFF_CLK_DIV    4'h9
`define DUR_OFF_SYS_CTRL   4'hA
`define DUR_OFF_SYS_STAT   4'hB
`define DUR_OFF_CRC_STAT   4'hC
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DUR_BIT_LINK_OFF   2
`define DUR_BIT_KEY_FLAG   5
`define DUR_BIT_HOLD       0
`define DUR_BIT_DONE       1
`define DUR_BIT_READY      2
`define DUR_BIT_ASLEEP     4
// ------------------------------------------------------------
// values and reset values
// ------------------------------------------------------------
`define DUR_RESET_SIG      8'h59
`define DUR_RUN_SIG        8'h00
`define DUR_ROW_KEY        64'h4E564D5573267465
`define DUR_REVISION_RST   8'h10
`define DUR_CLK_DIV_RST    8'h03
`define DUR_ZERO_BYTE      8'h00
`define DUR_BUF_LAST       9'h1FF
`define DUR_BUF_LIMIT      16'h0200
`endif

// ===== design/debug_user_row_pkg.sv
package debug_user_row_pkg;
   // copy engine states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_COPY   = 3'b010,
      ST_FINISH = 3'b100
   } copy_state_t;
endpackage : debug_user_row_pkg

// ===== design/debug_user_row_program_sleep.sv
`timescale 1ns/1ps
`include "debug_user_row_map.svh"

// Contract
// R1: a locked device can reprogram its user row after the row write key sequence.
// R2: the debugger first shifts in the user row write key with the key instruction.
// R3: the debugger may read the key status flag to confirm the key took.
// R4: writing reset signature resets the system; writing zero then releases it.
// R5: the debugger polls the ready flag and writes data only once it reads one.
// R6: in this mode only the lowest 512 RAM bytes accept writes; others are dropped.
// R7: on completion the buffer is copied byte for byte into the user row.
// R8: the debugger writes the done flag after all row data sits in RAM.
// R9: the ready flag clears when programming ends; the debugger polls until zero.
// R10: the debugger writes the key status flag, then resets the system again.
// R11: RAM reads return nothing while user row programming mode is active.
// R12: a level sync event fires on every rising edge inside the sync character.
// R13: the block consumes no event inputs; it only generates events.
// R14: the link layer keeps working in every sleep mode.
// R15: with the system clock stopped, no system bus access is performed.
// R16: while enabled the block requests the system clock.
// R17: a status flag shows whether the system domain is asleep.
// R18: with the hold bit set the clock runs in sleep and sleep is emulated.
// R19: the hold bit defaults to one whenever the block is enabled.
// R20: the row write key is the fixed 64-bit signature, least bit first.
// R21: reset signature requests system reset, zero clears, other values reserved.
// R22: the key status flag sets when the row write key is decoded.
// R23: a done write is ignored unless the ready flag is set.
module debug_user_row_program_sleep (
   input  wire logic        mclk,
   input  wire logic        reset,
   // register access from the link layer
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata_q,
   // key instruction
   input  wire logic        key_valid,
   input  wire logic [63:0] key_data,
   // memory accesses from the link layer
   input  wire logic        ram_wr_req,
   input  wire logic        ram_rd_req,
   input  wire logic [15:0] ram_addr,
   input  wire logic [7:0]  ram_wdata,
   output logic             ram_we_q,
   output logic             ram_re_q,
   output logic      [15:0] ram_addr_q,
   output logic      [7:0]  ram_wdata_q,
   output logic             ram_rd_refused_q,
   // user row write port
   input  wire logic        nvm_ready,
   output logic             nvm_we_q,
   output logic      [8:0]  nvm_addr_q,
   output logic      [7:0]  nvm_data_q,
   // sync character and event
   input  wire logic        sync_pin,
   input  wire logic        sync_window,
   output logic             sync_event_q,
   // system domain
   input  wire logic        sys_asleep,
   input  wire logic        sys_clk_running,
   output logic             sys_reset_q,
   output logic             sys_clk_req_q,
   output logic             sys_clk_keep_q,
   output logic             sleep_emulate_q
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic                            sync1, sync2, sync_prev;
      logic                            slp1, slp2, clk1, clk2;
      logic                            event_o;
      logic [7:0]                      rdata;
      logic [7:0]                      link_ctrl, link_dis, clk_div, rst_req;
      logic                            key_flag, ready, hold;
      debug_user_row_pkg::copy_state_t state;
      logic [8:0]                      cnt;
      logic                            nvm_we;
      logic [8:0]                      nvm_addr;
      logic [7:0]                      nvm_data;
      logic                            ram_we, ram_re, refused;
      logic [15:0]                     ram_addr;
      logic [7:0]                      ram_wdata;
      logic                            sys_rst, clk_req, emulate, keep;
   } state_t;

   state_t     s_q;
   state_t     s_d;
   logic [7:0] row_buf [0:511];
   logic       buf_we;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic enabled;
      logic wr_rst, wr_key, wr_ctl, key_ok, row_mode, bus_ok;
      enabled  = 1'b0;
      wr_rst   = 1'b0;
      wr_key   = 1'b0;
      wr_ctl   = 1'b0;
      key_ok   = 1'b0;
      row_mode = 1'b0;
      bus_ok   = 1'b0;
      s_d      = s_q;
      buf_we   = 1'b0;
      // pins and foreign levels pass two flops first
      s_d.sync1 = sync_pin;
      s_d.sync2 = s_q.sync1;
      s_d.sync_prev = s_q.sync2;
      s_d.slp1  = sys_asleep;
      s_d.slp2  = s_q.slp1;
      s_d.clk1  = sys_clk_running;
      s_d.clk2  = s_q.clk1;
      // event cannot be masked and nothing feeds in from outside
      s_d.event_o = sync_window & s_q.sync2 & ~s_q.sync_prev; // R12 R13

      enabled  = ~s_q.link_dis[`DUR_BIT_LINK_OFF];
      wr_rst   = reg_wr & hit(reg_addr, `DUR_OFF_RST_REQ);
      wr_key   = reg_wr & hit(reg_addr, `DUR_OFF_KEY_STAT);
      wr_ctl   = reg_wr & hit(reg_addr, `DUR_OFF_SYS_CTRL);
      key_ok   = enabled & key_valid & (key_data == `DUR_ROW_KEY); // R20
      row_mode = s_q.key_flag;
      bus_ok   = s_q.clk2; // R15

      // register writes stay live whatever the sleep state
      if (reg_wr & hit(reg_addr, `DUR_OFF_LINK_CTRL)) s_d.link_ctrl = reg_wdata; // R14
      if (reg_wr & hit(reg_addr, `DUR_OFF_LINK_DIS)) s_d.link_dis = reg_wdata;
      if (reg_wr & hit(reg_addr, `DUR_OFF_CLK_DIV)) s_d.clk_div = reg_wdata;
      if (wr_rst) s_d.rst_req = reg_wdata; // R21
      if (wr_ctl) s_d.hold = reg_wdata[`DUR_BIT_HOLD]; // R18
      // key flag: writing the bit ends the session, a decode in the same cycle wins
      if (wr_key & reg_wdata[`DUR_BIT_KEY_FLAG]) s_d.key_flag = 1'b0;
      if (key_ok) s_d.key_flag = 1'b1; // R22 R1

      // release of the system reset with the key held opens the buffer
      if (wr_rst & (reg_wdata == `DUR_RUN_SIG) & (s_q.rst_req == `DUR_RESET_SIG)
          & s_q.key_flag & (s_q.state == debug_user_row_pkg::ST_IDLE)) begin
         s_d.ready = 1'b1; // R4 R1
      end

      // reset request follows the register the cycle it is written
      s_d.sys_rst = (s_d.rst_req == `DUR_RESET_SIG); // R21 R4

      // copy engine
      s_d.nvm_we = 1'b0;
      unique case (s_q.state)
         debug_user_row_pkg::ST_IDLE: begin
            if (wr_ctl & reg_wdata[`DUR_BIT_DONE] & s_q.ready) begin // R23
               s_d.state = debug_user_row_pkg::ST_COPY;
               s_d.cnt   = 9'h000;
            end
         end
         debug_user_row_pkg::ST_COPY: begin
            if (nvm_ready) begin
               s_d.nvm_we   = 1'b1; // R7
               s_d.nvm_addr = s_q.cnt;
               s_d.nvm_data = row_buf[s_q.cnt];
               s_d.cnt      = s_q.cnt + 9'h001;
               if (s_q.cnt == `DUR_BUF_LAST) begin
                  s_d.state = debug_user_row_pkg::ST_FINISH;
               end
            end
         end
         debug_user_row_pkg::ST_FINISH: begin
            s_d.ready = 1'b0; // R9
            s_d.state = debug_user_row_pkg::ST_IDLE;
         end
      endcase

      // memory path: in row mode only the buffer window takes writes
      s_d.ram_we  = 1'b0;
      s_d.ram_re  = 1'b0;
      s_d.refused = 1'b0;
      if (ram_wr_req & bus_ok & enabled) begin
         if (row_mode) begin
            buf_we = s_q.ready & (s_q.state == debug_user_row_pkg::ST_IDLE)
                     & (ram_addr < `DUR_BUF_LIMIT); // R6
         end else begin
            s_d.ram_we    = 1'b1;
            s_d.ram_addr  = ram_addr;
            s_d.ram_wdata = ram_wdata;
         end
      end
      if (ram_rd_req) begin
         if (row_mode | ~bus_ok | ~enabled) begin
            s_d.refused = 1'b1; // R11 R15
         end else begin
            s_d.ram_re   = 1'b1;
            s_d.ram_addr = ram_addr;
         end
      end

      // disabling drops keys, the session and the clock request
      if (s_d.link_dis[`DUR_BIT_LINK_OFF]) begin
         s_d.key_flag = 1'b0;
         s_d.ready    = 1'b0;
         s_d.hold     = 1'b1; // R19
         s_d.state    = debug_user_row_pkg::ST_IDLE;
      end
      s_d.clk_req = ~s_d.link_dis[`DUR_BIT_LINK_OFF]; // R16
      s_d.emulate = s_d.clk_req & s_d.hold & s_q.slp2; // R18
      s_d.keep    = s_d.clk_req & s_d.hold; // R18 R19

      // register reads
      if (reg_rd) begin
         unique case (1'b1)
            hit(reg_addr, `DUR_OFF_REVISION):  s_d.rdata = `DUR_REVISION_RST;
            hit(reg_addr, `DUR_OFF_LINK_CTRL): s_d.rdata = s_q.link_ctrl;
            hit(reg_addr, `DUR_OFF_LINK_DIS):  s_d.rdata = s_q.link_dis;
            hit(reg_addr, `DUR_OFF_CLK_DIV):   s_d.rdata = s_q.clk_div;
            hit(reg_addr, `DUR_OFF_RST_REQ):   s_d.rdata = s_q.rst_req;
            hit(reg_addr, `DUR_OFF_KEY_STAT): begin
               s_d.rdata = `DUR_ZERO_BYTE;
               s_d.rdata[`DUR_BIT_KEY_FLAG] = s_q.key_flag; // R22
            end
            hit(reg_addr, `DUR_OFF_SYS_CTRL): begin
               s_d.rdata = `DUR_ZERO_BYTE;
               s_d.rdata[`DUR_BIT_HOLD] = s_q.hold;
            end
            hit(reg_addr, `DUR_OFF_SYS_STAT): begin
               s_d.rdata = `DUR_ZERO_BYTE;
               s_d.rdata[`DUR_BIT_ASLEEP] = s_q.slp2; // R17
               s_d.rdata[`DUR_BIT_READY]  = s_q.ready; // R9
            end
            default: s_d.rdata = `DUR_ZERO_BYTE; // error, crc and holes read zero
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_q         <= '0;
         s_q.clk_div <= `DUR_CLK_DIV_RST;
         s_q.hold    <= 1'b1; // R19
         s_q.state   <= debug_user_row_pkg::ST_IDLE;
         s_q.clk_req <= 1'b1;
         s_q.keep    <= 1'b1; // R19
      end else begin
         s_q <= s_d;
      end
   end

   // buffer holds no control state, so it carries no reset
   always_ff @(posedge mclk) begin
      if (buf_we) row_buf[ram_addr[8:0]] <= ram_wdata; // R6
   end

   assign reg_rdata_q      = s_q.rdata;
   assign ram_we_q         = s_q.ram_we;
   assign ram_re_q         = s_q.ram_re;
   assign ram_addr_q       = s_q.ram_addr;
   assign ram_wdata_q      = s_q.ram_wdata;
   assign ram_rd_refused_q = s_q.refused;
   assign nvm_we_q         = s_q.nvm_we;
   assign nvm_addr_q       = s_q.nvm_addr;
   assign nvm_data_q       = s_q.nvm_data;
   assign sync_event_q     = s_q.event_o;
   assign sys_reset_q      = s_q.sys_rst;
   assign sys_clk_req_q    = s_q.clk_req;
   assign sys_clk_keep_q   = s_q.keep;
   assign sleep_emulate_q  = s_q.emulate;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_key_set;
      key_valid && key_data == `DUR_ROW_KEY && !s_q.link_dis[`DUR_BIT_LINK_OFF]
      && !reg_wr |=> s_q.key_flag;
   endproperty
   a_key_set: assert property (p_key_set) else $error("key decode missed"); // R22
   property p_rst_req;
      reg_wr && reg_addr == `DUR_OFF_RST_REQ
      |=> sys_reset_q == ($past(reg_wdata) == `DUR_RESET_SIG);
   endproperty
   a_rst_req: assert property (p_rst_req) else $error("reset request wrong"); // R21
   property p_win;
      ram_wr_req && s_q.key_flag |=> !ram_we_q;
   endproperty
   a_win: assert property (p_win) else $error("row mode write escaped"); // R6
   property p_no_read;
      ram_rd_req && s_q.key_flag |=> !ram_re_q && ram_rd_refused_q;
   endproperty
   a_no_read: assert property (p_no_read) else $error("readback in row mode"); // R11
   property p_done_gate;
      reg_wr && reg_addr == `DUR_OFF_SYS_CTRL && !s_q.ready
      && s_q.state == debug_user_row_pkg::ST_IDLE |=> s_q.state == debug_user_row_pkg::ST_IDLE;
   endproperty
   a_done_gate: assert property (p_done_gate) else $error("stray done started copy"); // R23
   property p_finish;
      s_q.state == debug_user_row_pkg::ST_FINISH |=> !s_q.ready ##1 !s_q.ready;
   endproperty
   a_finish: assert property (p_finish) else $error("ready not cleared"); // R9
   property p_copy_data;
      nvm_we_q |-> nvm_data_q == row_buf[nvm_addr_q];
   endproperty
   a_copy_data: assert property (p_copy_data) else $error("copy byte mismatch"); // R7
   property p_sync_evt;
      sync_window && s_q.sync2 && !s_q.sync_prev |=> sync_event_q;
   endproperty
   a_sync_evt: assert property (p_sync_evt) else $error("sync event missed"); // R12
   property p_clk_req;
      !s_q.link_dis[`DUR_BIT_LINK_OFF] |-> sys_clk_req_q;
   endproperty
   a_clk_req: assert property (p_clk_req) else $error("clock request low while enabled"); // R16
   property p_hold_dflt;
      $rose(s_q.link_dis[`DUR_BIT_LINK_OFF]) |-> s_q.hold ##1 s_q.hold;
   endproperty
   a_hold_dflt: assert property (p_hold_dflt) else $error("hold not defaulted"); // R19
   property p_bus_stop;
      ram_wr_req && !s_q.clk2 |=> !ram_we_q;
   endproperty
   a_bus_stop: assert property (p_bus_stop) else $error("bus access without clock"); // R15
   property p_asleep;
      reg_rd && reg_addr == `DUR_OFF_SYS_STAT |=> reg_rdata_q[`DUR_BIT_ASLEEP] == $past(s_q.slp2);
   endproperty
   a_asleep: assert property (p_asleep) else $error("asleep flag wrong"); // R17

   c_copy_done: cover property (s_q.state == debug_user_row_pkg::ST_FINISH);
   c_sync:      cover property (sync_event_q);
   c_reset:     cover property (sys_reset_q ##[1:50] !sys_reset_q);
   c_refused:   cover property (ram_rd_refused_q);

endmodule : debug_user_row_program_sleep

// ===== testbench/user_row_store.sv
`timescale 1ns/1ps

module user_row_store #(
   parameter int STALL_EVERY = 3
) (
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       nvm_we_q,
   input  wire logic [8:0] nvm_addr_q,
   input  wire logic [7:0] nvm_data_q,
   output logic            nvm_ready
);
   logic [7:0] row [0:511];
   int         n_writes;
   int         tick_q;

   // -------------------------------------------
   // pacing and capture
   // -------------------------------------------
   // refuse one cycle in every few so the copy engine has to wait on us
   always @(posedge mclk) begin
      if (reset) begin
         tick_q   <= 0;
         n_writes <= 0;
      end else begin
         tick_q <= (tick_q + 1) % STALL_EVERY;
         if (nvm_we_q === 1'b1) begin
            row[nvm_addr_q] <= nvm_data_q;
            n_writes        <= n_writes + 1;
         end
      end
   end

   // never ready in reset, so no byte can slip through early
   assign nvm_ready = (tick_q != 0) && !reset;
endmodule : user_row_store

// ===== testbench/debug_user_row_program_sleep_tb_top.sv
`timescale 1ns/1ps

module debug_user_row_program_sleep_tb_top;
   logic        mclk        = 1'b0;
   logic        reset       = 1'b1;
   logic        reg_wr      = 1'b0;
   logic        reg_rd      = 1'b0;
   logic [3:0]  reg_addr    = 4'h0;
   logic [7:0]  reg_wdata   = 8'h00;
   logic        key_valid   = 1'b0;
   logic [63:0] key_data    = 64'h0;
   logic        ram_wr_req  = 1'b0;
   logic        ram_rd_req  = 1'b0;
   logic [15:0] ram_addr    = 16'h0;
   logic [7:0]  ram_wdata   = 8'h00;
   logic        sync_pin    = 1'b0;
   logic        sync_window = 1'b0;
   logic        sys_asleep  = 1'b0;
   logic        sys_clk_run = 1'b1;
   logic [7:0]  reg_rdata_q, ram_wdata_q, nvm_data_q;
   logic [15:0] ram_addr_q;
   logic [8:0]  nvm_addr_q;
   logic        ram_we_q, ram_re_q, ram_rd_refused_q, nvm_ready, nvm_we_q, sync_event_q;
   logic        sys_reset_q, sys_clk_req_q, sys_clk_keep_q, sleep_emulate_q;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          n_sync = 0;

   always #2 mclk = ~mclk;

   debug_user_row_program_sleep debug_user_row_program_sleep_i (
      .mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .key_valid(key_valid),
      .key_data(key_data), .ram_wr_req(ram_wr_req), .ram_rd_req(ram_rd_req),
      .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we_q(ram_we_q), .ram_re_q(ram_re_q),
      .ram_addr_q(ram_addr_q), .ram_wdata_q(ram_wdata_q), .ram_rd_refused_q(ram_rd_refused_q),
      .nvm_ready(nvm_ready), .nvm_we_q(nvm_we_q), .nvm_addr_q(nvm_addr_q),
      .nvm_data_q(nvm_data_q), .sync_pin(sync_pin), .sync_window(sync_window),
      .sync_event_q(sync_event_q), .sys_asleep(sys_asleep), .sys_clk_running(sys_clk_run),
      .sys_reset_q(sys_reset_q), .sys_clk_req_q(sys_clk_req_q),
      .sys_clk_keep_q(sys_clk_keep_q), .sleep_emulate_q(sleep_emulate_q));

   user_row_store user_row_store_i (
      .mclk(mclk), .reset(reset), .nvm_we_q(nvm_we_q), .nvm_addr_q(nvm_addr_q),
      .nvm_data_q(nvm_data_q), .nvm_ready(nvm_ready));

   // -------------------------------------------
   // access tasks
   // -------------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] expected);
      samples_checked++;
      if (seen !== expected) begin
         n_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expected);
      end
   endtask : check

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask : reg_read

   task automatic reg_expect(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] d;
      reg_read(a, d);
      check(64'(d), 64'(e));
   endtask : reg_expect

   // outputs of the issued access are looked at in their one-cycle slot
   task automatic ram_access(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      ram_wr_req <= wr;
      ram_rd_req <= !wr;
      ram_addr   <= a;
      ram_wdata  <= d;
      @(posedge mclk);
      ram_wr_req <= 1'b0;
      ram_rd_req <= 1'b0;
      #1;
   endtask : ram_access

   task automatic send_key(input logic [63:0] k);
      @(posedge mclk);
      key_valid <= 1'b1;
      key_data  <= k;
      @(posedge mclk);
      key_valid <= 1'b0;
   endtask : send_key

   function automatic logic [7:0] pat(input int i);
      return i[7:0] ^ 8'hA5;
   endfunction : pat

   task automatic results;
      $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results

   always @(posedge mclk) begin
      if (sync_event_q === 1'b1) n_sync++;
   end

   // a hang in a poll loop must still reach the verdict
   initial begin
      #80000;
      n_errors++;
      results();
   end

   // -------------------------------------------
   // tests
   // -------------------------------------------
   initial begin
      logic [7:0] d;
      int         polls;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1 check(64'(sys_clk_req_q), 64'h1);
      check(64'(sys_clk_keep_q), 64'h1);
      reg_expect(4'h0, 8'h10);
      reg_expect(4'h9, 8'h03);
      reg_expect(4'hA, 8'h01);
      reg_expect(4'h5, 8'h00);
      reg_expect(4'h7, 8'h00);
      // a stray done write with no session open
      reg_write(4'hA, 8'h03);
      repeat (6) @(posedge mclk);
      check(64'(user_row_store_i.n_writes), 64'h0);
      reg_expect(4'hB, 8'h00);
      send_key(64'h4E564D5573267465 ^ 64'h1);
      reg_expect(4'h7, 8'h00);
      send_key(64'h4E564D5573267465);
      reg_expect(4'h7, 8'h20);
      reg_write(4'h8, 8'h59);
      @(posedge mclk);
      #1 check(64'(sys_reset_q), 64'h1);
      reg_expect(4'h8, 8'h59);
      reg_write(4'h8, 8'h00);
      @(posedge mclk);
      #1 check(64'(sys_reset_q), 64'h0);
      reg_expect(4'hB, 8'h04);
      // fill the buffer, then one write just past its end
      for (int i = 0; i < 512; i++) begin
         ram_access(1'b1, 16'(i), pat(i));
         check(64'(ram_we_q), 64'h0);
      end
      ram_access(1'b1, 16'h0200, ~pat(0));
      check(64'(ram_we_q), 64'h0);
      ram_access(1'b0, 16'h0010, 8'h00);
      check(64'(ram_rd_refused_q), 64'h1);
      check(64'(ram_re_q), 64'h0);
      reg_write(4'hA, 8'h03);
      polls = 0;
      d = 8'h04;
      while (d[2] === 1'b1 && polls < 800) begin
         reg_read(4'hB, d);
         polls++;
      end
      reg_expect(4'hB, 8'h00);
      check(64'(user_row_store_i.n_writes), 64'h200);
      for (int i = 0; i < 512; i++) begin
         check(64'(user_row_store_i.row[i]), 64'(pat(i)));
      end
      reg_write(4'h7, 8'h20);
      reg_expect(4'h7, 8'h00);
      reg_write(4'h8, 8'h59);
      reg_write(4'h8, 8'h00);
      reg_expect(4'hB, 8'h00);
      // plain memory traffic once the session is closed
      ram_access(1'b1, 16'h0345, 8'h3C);
      check(64'({ram_we_q, ram_addr_q, ram_wdata_q}), 64'({1'b1, 16'h0345, 8'h3C}));
      ram_access(1'b0, 16'h0345, 8'h00);
      check(64'({ram_re_q, ram_rd_refused_q}), 64'h2);
      // sleep with the clock held, then released; pins move on the edge
      @(posedge mclk);
      sys_asleep <= 1'b1;
      repeat (4) @(posedge mclk);
      reg_expect(4'hB, 8'h10);
      check(64'({sleep_emulate_q, sys_clk_keep_q}), 64'h3);
      reg_write(4'hA, 8'h00);
      repeat (2) @(posedge mclk);
      #1 check(64'({sleep_emulate_q, sys_clk_keep_q, sys_clk_req_q}), 64'h1);
      @(posedge mclk);
      sys_clk_run <= 1'b0;
      repeat (4) @(posedge mclk);
      ram_access(1'b1, 16'h0020, 8'h11);
      check(64'(ram_we_q), 64'h0);
      ram_access(1'b0, 16'h0020, 8'h00);
      check(64'({ram_re_q, ram_rd_refused_q}), 64'h1);
      reg_expect(4'hB, 8'h10);
      @(posedge mclk);
      sys_clk_run <= 1'b1;
      sys_asleep  <= 1'b0;
      // two rising edges inside the window, two outside it
      sync_window <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         if (k == 4) sync_window <= 1'b0;
         @(posedge mclk);
         sync_pin <= ~sync_pin;
         repeat (6) @(posedge mclk);
      end
      check(64'(n_sync), 64'h2);
      reg_write(4'h3, 8'h04);
      repeat (2) @(posedge mclk);
      #1 check(64'(sys_clk_req_q), 64'h0);
      reg_write(4'h3, 8'h00);
      repeat (2) @(posedge mclk);
      #1 check(64'(sys_clk_req_q), 64'h1);
      reg_expect(4'hA, 8'h01);
      results();
   end
endmodule : debug_user_row_program_sleep_tb_top
